// [src/ctc_params.svh]
// timing counts, register map and reset values of the coax transceiver
`ifndef CTC_PARAMS_SVH
`define CTC_PARAMS_SVH
`define CTC_CLK_NS     25
`define CTC_RX_ON_NS   500
`define CTC_RX_ON_CYC  (`CTC_RX_ON_NS / `CTC_CLK_NS)
`define CTC_RX_HI_NS   250
`define CTC_RX_HI_CYC  (`CTC_RX_HI_NS / `CTC_CLK_NS)
`define CTC_RX_BLK_NS  1000
`define CTC_RX_BLK_CYC (`CTC_RX_BLK_NS / `CTC_CLK_NS)
`define CTC_TX_ON_NS   15
`define CTC_TX_ON_CYC  ((`CTC_TX_ON_NS + `CTC_CLK_NS - 1) / `CTC_CLK_NS)
`define CTC_TX_OFF_NS  250
`define CTC_TX_OFF_CYC (`CTC_TX_OFF_NS / `CTC_CLK_NS)
`define CTC_COL_NS     700
`define CTC_COL_CYC    (`CTC_COL_NS / `CTC_CLK_NS)
`define CTC_COL_HI_NS  170
`define CTC_COL_HI_CYC ((`CTC_COL_HI_NS + `CTC_CLK_NS - 1) / `CTC_CLK_NS)
`define CTC_HB_DLY_NS  1000
`define CTC_HB_DLY_CYC (`CTC_HB_DLY_NS / `CTC_CLK_NS)
`define CTC_HB_LEN_NS  1000
`define CTC_HB_LEN_CYC (`CTC_HB_LEN_NS / `CTC_CLK_NS)
`define CTC_JAB_MS     30
`define CTC_JAB_CYC    (`CTC_JAB_MS * 1000000 / `CTC_CLK_NS)
`define CTC_UNJAB_NS   450
`define CTC_UNJAB_CYC  (`CTC_UNJAB_NS / `CTC_CLK_NS)
`define CTC_REG_CTRL   2'h0
`define CTC_REG_STAT   2'h1
`define CTC_REG_EVT    2'h2
`define CTC_CTRL_RST   2'h3
`define CTC_FIFO_W     8
`define CTC_FIFO_D     16
`endif

// [src/ctc_pkg.sv]
// types shared by the coax transceiver control logic
package ctc_pkg;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_ON    = 2'b01,
    RX_BLANK = 2'b10
  } ctc_rx_t;
  typedef enum logic [1:0] {
    HB_IDLE  = 2'b00,
    HB_WAIT  = 2'b01,
    HB_BURST = 2'b10
  } ctc_hb_t;
  typedef enum logic [7:0] {
    EV_RX_START = 8'h01,
    EV_RX_END   = 8'h02,
    EV_COL      = 8'h03,
    EV_HB       = 8'h04,
    EV_JAB      = 8'h05
  } ctc_ev_t;
  typedef struct packed {
    logic [5:0]  s1;       // first sync stage
    logic [5:0]  s2;       // second sync stage
    ctc_rx_t     rx_st;
    logic [5:0]  rx_cnt;
    logic        rx_en;
    logic        rx_data;
    logic        tx_act;
    logic        tx_en;
    logic        tx_out;
    logic [3:0]  tx_cnt;
    logic [20:0] jab_cnt;
    logic        jabbed;
    logic [4:0]  unjab_cnt;
    ctc_hb_t     hb_st;
    logic [5:0]  hb_cnt;
    logic        col_run;
    logic [1:0]  ph;
    logic [3:0]  hi_hold;
    logic [1:0]  col_out;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  ctrl;
    logic        ovf;
  } ctc_st_t;
endpackage

// [src/ctc_coax_transceiver.sv]
// coax transceiver control: squelch, collision, heartbeat, jabber, regs
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`include "ctc_params.svh"

module ctc_fifo import ctc_pkg::*; #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         CLK,       // system clock
  input  wire logic         SYS_RST,   // sync reset
  input  wire logic         CE,        // clock enable
  input  wire logic         in_valid,  // push request
  output logic              in_ready,  // room left
  input  wire logic [W-1:0] in_data,   // pushed word
  output logic              out_valid, // word available
  input  wire logic         out_ready, // pop request
  output logic [W-1:0]      out_data   // head word
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } ctc_fifo_st_t;
  ctc_fifo_st_t q, d;
  logic push;
  logic pop;

  // handshake terms
  assign in_ready  = q.cnt != (AW+1)'(D);
  assign out_valid = q.cnt != '0;
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      q <= '0;
    end else if (CE) begin
      q <= d;
    end
  end
endmodule

module ctc_coax_transceiver import ctc_pkg::*; #(
  parameter int JAB_CYC = `CTC_JAB_CYC
) (
  input  wire logic        CLK,                 // 40 MHz clock
  input  wire logic        SYS_RST,             // sync reset, high
  input  wire logic        CE,                  // clock enable
  input  wire logic        RX_SQUELCH_IN,       // dc below squelch level
  input  wire logic        COL_THRESH_IN,       // dc below collision level
  input  wire logic        TX_NEG_IN,           // qualified negative input
  input  wire logic        TX_DATA_IN,          // transmit data bit
  input  wire logic        CABLE_SENSE_IN,      // cable data level
  input  wire logic        HEARTBEAT_ENABLE_IN, // low disables heartbeat
  output logic             RX_DATA_OUT,         // receive data
  output logic             RX_EN_OUT,           // receiver enabled
  output logic             TX_OUT,              // transmit to cable
  output logic             TX_EN_OUT,           // transmitter enabled
  output logic [1:0]       COLLISION_OUT_PAIR,  // 10=high 01=low 00=idle
  input  wire logic [3:0]  AVS_ADDRESS,         // byte address
  input  wire logic        AVS_READ,            // read strobe
  input  wire logic        AVS_WRITE,           // write strobe
  input  wire logic [31:0] AVS_WRITEDATA,       // write data
  output logic [31:0]      AVS_READDATA,        // read data
  output logic             AVS_WAITREQUEST      // stall
);
  localparam logic [1:0]  P_HI   = 2'b10;
  localparam logic [1:0]  P_LO   = 2'b01;
  localparam logic [20:0] JAB_LIM = 21'(JAB_CYC - 1);

  ctc_st_t q, d;
  logic       col_req;
  logic       req;
  logic       take;
  logic       ev_valid;
  logic [7:0] ev_code;
  logic       ev_ready;
  logic       pop;
  logic       f_valid;
  logic [7:0] f_data;

  // is the counter at the given terminal count
  function automatic logic at(input logic [20:0] c, input int n);
    at = c >= 21'(n - 1);
  endfunction

  // bus handshake: one stall cycle then accept
  // read data is captured in the stall cycle, so it stands at the accept
  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~q.ack;
  assign take            = req & q.ack;
  assign pop = take & AVS_READ & (AVS_ADDRESS[3:2] == `CTC_REG_EVT);

  // collision sources: threshold, heartbeat, jabber
  assign col_req = q.s2[1] | (q.hb_st == HB_BURST) | q.jabbed;

  // outputs from flops
  assign RX_DATA_OUT        = q.rx_data;
  assign RX_EN_OUT          = q.rx_en;
  assign TX_OUT             = q.tx_out;
  assign TX_EN_OUT          = q.tx_en;
  assign COLLISION_OUT_PAIR = q.col_out;
  assign AVS_READDATA       = q.rdata;

  // event log of the link activity
  always_comb begin
    ev_valid = 1'b1;
    ev_code  = EV_COL;
    if (d.jabbed & ~q.jabbed) begin
      ev_code = EV_JAB;
    end else if (d.rx_en & ~q.rx_en) begin
      ev_code = EV_RX_START;
    end else if (~d.rx_en & q.rx_en) begin
      ev_code = EV_RX_END;
    end else if (d.hb_st == HB_BURST && q.hb_st != HB_BURST) begin
      ev_code = EV_HB;
    end else if (~(d.col_run & ~q.col_run)) begin
      ev_valid = 1'b0;
    end
  end

  ctc_fifo #(.W(`CTC_FIFO_W), .D(`CTC_FIFO_D)) u_fifo (
    .CLK       (CLK),
    .SYS_RST   (SYS_RST),
    .CE        (CE),
    .in_valid  (ev_valid),
    .in_ready  (ev_ready),
    .in_data   (ev_code),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  // next state of the whole block
  always_comb begin
    d    = q;
    // two-stage sync of the six line pins before any logic reads them; the bus, CE and reset pins are used directly
    d.s1 = {HEARTBEAT_ENABLE_IN, CABLE_SENSE_IN, TX_DATA_IN,
            TX_NEG_IN, COL_THRESH_IN, RX_SQUELCH_IN};
    d.s2 = q.s1;
    // receiver squelch and end of packet blanking
    case (q.rx_st)
      RX_IDLE: begin
        d.rx_cnt = '0;
        if (q.s2[0]) begin
          d.rx_st = RX_ON;
          d.rx_en = 1'b1;
        end
      end
      RX_ON: begin
        d.rx_cnt = q.s2[4] ? q.rx_cnt + 1'b1 : '0;
        if (q.s2[4] && at(21'(q.rx_cnt), `CTC_RX_HI_CYC)) begin
          d.rx_st  = RX_BLANK;
          d.rx_en  = 1'b0;
          d.rx_cnt = '0;
        end
      end
      RX_BLANK: begin
        d.rx_cnt = q.rx_cnt + 1'b1;
        if (at(21'(q.rx_cnt), `CTC_RX_BLK_CYC)) begin
          d.rx_st = RX_IDLE;
        end
      end
      default: begin
        d.rx_st = RX_IDLE;
        d.rx_en = 1'b0;
      end
    endcase
    // receive data only from the cable
    d.rx_data = q.s2[4] & d.rx_en;
    // transmit squelch: start on excursion, stop after quiet time
    if (q.s2[2]) begin
      d.tx_act = 1'b1;
      d.tx_cnt = '0;
    end else if (q.tx_act) begin
      d.tx_cnt = q.tx_cnt + 1'b1;
      if (at(21'(q.tx_cnt), `CTC_TX_OFF_CYC)) begin
        d.tx_act = 1'b0;
      end
    end
    // jabber timer and unjab interval
    d.jab_cnt = q.tx_en ? q.jab_cnt + 1'b1 : '0;
    if (q.tx_en && q.jab_cnt >= JAB_LIM) begin
      d.jabbed = 1'b1;
    end
    d.unjab_cnt = '0;
    if (q.jabbed && !d.tx_act) begin
      d.unjab_cnt = q.unjab_cnt + 1'b1;
      if (at(21'(q.unjab_cnt), `CTC_UNJAB_CYC)) begin
        d.jabbed = 1'b0;
      end
    end
    d.tx_en  = d.tx_act & ~d.jabbed & q.ctrl[1];
    d.tx_out = d.tx_en & q.s2[3];
    // heartbeat after each transmission end not caused by jabber
    case (q.hb_st)
      HB_IDLE: begin
        d.hb_cnt = '0;
        if (q.tx_en && !d.tx_en && !d.jabbed && q.s2[5] && q.ctrl[0]) begin
          d.hb_st = HB_WAIT;
        end
      end
      HB_WAIT: begin
        d.hb_cnt = q.hb_cnt + 1'b1;
        if (at(21'(q.hb_cnt), `CTC_HB_DLY_CYC)) begin
          d.hb_st  = HB_BURST;
          d.hb_cnt = '0;
        end
      end
      HB_BURST: begin
        d.hb_cnt = q.hb_cnt + 1'b1;
        if (at(21'(q.hb_cnt), `CTC_HB_LEN_CYC)) begin
          d.hb_st = HB_IDLE;
        end
      end
      default: d.hb_st = HB_IDLE;
    endcase
    // collision oscillator: low half first, 4 cycles per period
    if (col_req) begin
      d.col_run = 1'b1;
      d.ph      = q.col_run ? q.ph + 1'b1 : 2'h0;
      d.col_out = d.ph[1] ? P_HI : P_LO;
      d.hi_hold = '0;
    end else if (q.col_run) begin
      d.col_run = 1'b0;
      d.hi_hold = 4'(`CTC_COL_HI_CYC);
      d.col_out = P_HI;
    end else if (q.hi_hold != '0) begin
      d.hi_hold = q.hi_hold - 1'b1;
      d.col_out = (q.hi_hold == 4'h1) ? 2'b00 : P_HI;
    end else begin
      d.col_out = 2'b00;
    end
    // register bus
    // ack alternates so every request costs exactly two cycles
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      case (AVS_ADDRESS[3:2])
        `CTC_REG_CTRL: d.rdata = {30'h0, q.ctrl};
        `CTC_REG_STAT: d.rdata = {24'h0, ~f_valid, q.ovf, q.jabbed,
                                  q.col_run, q.hb_st == HB_BURST,
                                  q.tx_en, q.rx_en, q.tx_act};
        `CTC_REG_EVT:  d.rdata = {23'h0, f_valid, f_data};
        default:       d.rdata = 32'h0;
      endcase
    end
    if (take && AVS_WRITE && AVS_ADDRESS[3:2] == `CTC_REG_CTRL) begin
      d.ctrl = AVS_WRITEDATA[1:0];
    end
    if (take && AVS_WRITE && AVS_ADDRESS[3:2] == `CTC_REG_STAT &&
        AVS_WRITEDATA[6]) begin
      d.ovf = 1'b0;
    end
    if (ev_valid && !ev_ready) begin
      d.ovf = 1'b1; // set wins over clear
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      q       <= '0;
      q.ctrl  <= `CTC_CTRL_RST;
      q.rx_st <= RX_IDLE;
      q.hb_st <= HB_IDLE;
    end else if (CE) begin
      q <= d;
    end
  end


  // checks on the qualified flags and timers, frozen while CE is low
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST || !CE);

  chk_rx_on_time: assert property (
    q.rx_st == RX_IDLE && q.s2[0] && CE |=> q.rx_en)
    else $error("receiver not enabled after squelch");
  chk_rx_blank_hold: assert property (
    $fell(q.rx_en) && q.rx_st == RX_BLANK |-> !q.rx_en [*8])
    else $error("receiver re-enabled during blanking");
  chk_tx_start_on: assert property (
    !q.tx_act && q.s2[2] && !q.jabbed && q.ctrl[1] && CE |=> q.tx_en)
    else $error("transmitter not started");
  chk_tx_quiet_off: assert property (
    q.tx_act && !q.s2[2] && q.tx_cnt == 4'h9 && CE |=> !q.tx_act)
    else $error("transmitter not stopped after quiet");
  chk_col_onset: assert property (
    q.s2[1] |-> ##[1:28] q.col_run)
    else $error("collision not shown in time");
  chk_col_first_low: assert property (
    $rose(q.col_run) |-> COLLISION_OUT_PAIR == P_LO)
    else $error("collision did not open low");
  chk_col_tail_high: assert property (
    $fell(q.col_run) ##0 (!col_req) [*7] |-> COLLISION_OUT_PAIR == P_HI)
    else $error("collision tail not held high");
  chk_hb_disabled: assert property (
    q.hb_st == HB_IDLE && !q.s2[5] |=> q.hb_st == HB_IDLE)
    else $error("heartbeat started while disabled");
  chk_jab_inhibit: assert property (
    q.jabbed |-> !q.tx_en && !TX_OUT)
    else $error("transmit while jabbed");
  chk_jab_col_out: assert property (
    q.jabbed |=> q.col_run)
    else $error("no collision during jabber");
  chk_rx_no_loop: assert property (
    RX_DATA_OUT |-> $past(q.s2[4]) && q.rx_en)
    else $error("receive data not from cable");

  // heartbeat opens after the full wait count
  chk_hb_after_tx: assert property (
    q.hb_st == HB_WAIT && q.hb_cnt == 6'd39 |=> q.hb_st == HB_BURST)
    else $error("heartbeat burst not started");
  // unjab releases the inhibit after the quiet count
  chk_unjab_clear: assert property (
    q.jabbed && !q.tx_act && !q.s2[2] && q.unjab_cnt == 5'd17
    |=> !q.jabbed)
    else $error("transmitter inhibit not released");
  // a dropped event is always remembered
  chk_ovf_sticky: assert property (
    ev_valid && !ev_ready |=> q.ovf)
    else $error("event overflow not flagged");


  cov_rx_packet: cover property ($fell(q.rx_en));
  cov_heartbeat: cover property (q.hb_st == HB_BURST);
  cov_collision: cover property ($rose(q.col_run) && q.s2[1]);
  cov_jabber:    cover property ($fell(q.jabbed));
  cov_overflow:  cover property ($rose(q.ovf));
endmodule

// [verif/ctc_sni_model.sv]
// terminal-side encoder model driving the transmit inputs
module ctc_sni_model (
  input  wire logic clk,        // system clock
  input  wire logic send,       // frame request from bench
  input  wire logic rx_data,    // receive data from device
  output logic      tx_neg,     // qualified negative excursion
  output logic      tx_data,    // transmit data level
  output logic      short_seen  // own frame got no echo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic echo;
  initial begin
    tx_neg = 1'b0;
    tx_data = 1'b0;
    echo = 1'b0;
    short_seen = 1'b0;
  end
  // data toggles every cycle, idle too, so no stale level lingers
  always @(posedge clk) begin
    tx_neg <= send;
    tx_data <= ~tx_data;
    if (send && rx_data) begin
      echo <= 1'b1;
    end
    // frame end without echo flags a shorted connector
    if (tx_neg && !send) begin
      short_seen <= !echo;
      echo <= 1'b0;
    end
  end
endmodule

// [verif/ctc_coax_transceiver_test.sv]
// self-checking bench for the coax transceiver control block
module ctc_coax_transceiver_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int JAB = 200;
  logic        clk = 0, sys_rst = 1, squelch = 0, col_th = 0;
  logic        cable = 0, heartbeat_enable_in = 1, send = 0, leak = 0, ce = 1;
  logic        tx_neg, tx_data, rx_data, rx_en, tx_out, tx_en, short_seen;
  logic [1:0]  pair;
  logic [3:0]  addr = 0;
  logic        rd = 0, wr = 0, wait_req;
  logic [31:0] wdata = 0, rdata, v;
  int          seed = 32'ha7f1cd81;
  int          miscompares = 0, num_checks = 0, cyc = 0, n, hi, i;

  ctc_coax_transceiver #(.JAB_CYC(JAB)) uut (
    .CLK(clk), .SYS_RST(sys_rst), .CE(ce),
    .RX_SQUELCH_IN(squelch), .COL_THRESH_IN(col_th),
    .TX_NEG_IN(tx_neg), .TX_DATA_IN(tx_data), .CABLE_SENSE_IN(cable),
    .HEARTBEAT_ENABLE_IN(heartbeat_enable_in), .RX_DATA_OUT(rx_data), .RX_EN_OUT(rx_en),
    .TX_OUT(tx_out), .TX_EN_OUT(tx_en), .COLLISION_OUT_PAIR(pair),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req));
  ctc_sni_model sni (
    .clk(clk), .send(send), .rx_data(rx_data), .tx_neg(tx_neg),
    .tx_data(tx_data), .short_seen(short_seen));

  // 40 MHz clock
  always #12.5 clk = ~clk;
  // hang guard and loopback watch during own frames
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (send === 1'b1 && rx_data !== 1'b0) begin
      leak <= 1'b1;
    end
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  function automatic int cyc_of(input int ns);
    return ns / 25;
  endfunction
  function automatic logic probe(input int sel);
    case (sel)
      0: return rx_en;
      1: return tx_en;
      default: return pair !== 2'b00;
    endcase
  endfunction
  function automatic logic [1:0] osc_of(input int k);
    return (k % 4 < 2) ? 2'b01 : 2'b10;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do @(posedge clk); while (wait_req !== 1'b0);
    v = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_for(input int sel, input logic val, input int lim);
    n = 0;
    while (probe(sel) !== val && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic frame(input int len);
    send <= 1'b1;
    repeat (len) @(posedge clk);
    send <= 1'b0;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(0, 4'h0, 0);
    check("ctrl reset", v, 32'h3);
    bus(1, 4'hc, 32'hffffffff);
    bus(0, 4'hc, 0);
    check("unmapped", v, 32'h0);
    bus(1, 4'h0, 0);
    bus(0, 4'h0, 0);
    check("ctrl write", v, 32'h0);
    bus(1, 4'h0, 32'h3);
    // receiver on, then shut by a steady high, then blanked
    squelch <= 1'b1;
    wait_for(0, 1, 60);
    check("rx on", n <= cyc_of(500), 1);
    cable <= 1'b1;
    wait_for(0, 0, 40);
    check("rx off", n >= 10 && n <= 14, 1);
    cable <= 1'b0;
    wait_for(0, 1, 80);
    check("rx blank", n >= 38 && n <= 44, 1);
    squelch <= 1'b0;
    wait_for(0, 0, 20);
    // transmit frame with heartbeat after it
    send <= 1'b1;
    wait_for(1, 1, 20);
    check("tx on", n <= 6, 1);
    repeat (30 + ($random(seed) & 31)) @(posedge clk);
    send <= 1'b0;
    wait_for(1, 0, 40);
    check("tx off", n >= 10 && n <= 15, 1);
    wait_for(2, 1, 80);
    check("hb delay", n >= 38 && n <= 43, 1);
    wait_for(2, 0, 80);
    check("hb length", n >= 40 && n <= 50, 1);
    check("no loopback", leak, 0);
    check("short seen", short_seen, 1);
    // heartbeat pin low
    heartbeat_enable_in <= 1'b0;
    frame(20 + ($random(seed) & 15));
    wait_for(1, 0, 40);
    wait_for(2, 1, 100);
    check("hb off", n, 100);
    heartbeat_enable_in <= 1'b1;
    // collision onset, oscillation, steady presence and tail
    col_th <= 1'b1;
    wait_for(2, 1, 40);
    check("col delay", n <= cyc_of(700), 1);
    check("col first", pair, 2'b01);
    for (i = 1; i < 8; i++) begin
      @(posedge clk);
      check("col osc", pair, osc_of(i));
    end
    wait_for(2, 0, 60);
    check("col steady", n, 60);
    col_th <= 1'b0;
    hi = 0;
    for (n = 0; n < 60 && pair !== 2'b00; n++) begin
      hi = (pair === 2'b10) ? hi + 1 : 0;
      @(posedge clk);
    end
    check("col tail", hi >= 7 && n < 60, 1);
    // jabber trip, unjab and release
    send <= 1'b1;
    wait_for(1, 1, 20);
    wait_for(1, 0, JAB + 20);
    check("jab time", n >= JAB - 1 && n <= JAB + 2, 1);
    repeat (20) @(posedge clk);
    check("jab col", pair !== 2'b00, 1);
    send <= 1'b0;
    wait_for(2, 0, 80);
    check("unjab", n >= 28 && n <= 45, 1);
    send <= 1'b1;
    wait_for(1, 1, 20);
    check("jab release", n <= 6, 1);
    send <= 1'b0;
    repeat (120) @(posedge clk);
    // drain events, overflow the queue with collisions, drain again
    for (i = 0; i < 24; i++) begin
      bus(0, 4'h8, 0);
      if (v[8] !== 1'b1) break;
    end
    repeat (17 + ($random(seed) & 3)) begin
      col_th <= 1'b1;
      repeat (6) @(posedge clk);
      col_th <= 1'b0;
      repeat (20) @(posedge clk);
    end
    bus(0, 4'h4, 0);
    check("overflow", v[7:6], 2'b01);
    for (i = 0; i < 16; i++) begin
      bus(0, 4'h8, 0);
      check("col event", v[8:0], 9'h103);
    end
    bus(0, 4'h8, 0);
    check("queue empty", v[8], 0);
    bus(1, 4'h4, 32'h40);
    bus(0, 4'h4, 0);
    check("ovf clear", v[7:6], 2'b10);
    // clock enable low freezes the running collision pattern
    col_th <= 1'b1;
    wait_for(2, 1, 40);
    ce <= 1'b0;
    @(posedge clk);
    v = {30'h0, pair};
    repeat (5) @(posedge clk);
    check("ce freeze pair", pair, v[1:0]);
    check("ce freeze rx", rx_en, 1);
    ce <= 1'b1;
    col_th <= 1'b0;
    repeat (20) @(posedge clk);
    summarize();
  end
endmodule
